// *** rtl/sed_defs.svh ***
// Constants shared by both ends of the serial EEPROM command link.
// Assumes core_clk runs at 50 MHz and is common to both ends.
`ifndef SED_DEFS_SVH
`define SED_DEFS_SVH

// ==========================================
// Opcodes and sub-commands
`define SED_OP_CTRL 2'h0
`define SED_OP_WRITE 2'h1
`define SED_OP_READ 2'h2
`define SED_OP_ERASE 2'h3
`define SED_PROGRAM_DISABLE_CMD 2'h0
`define SED_FILL_EVERYTHING_CMD 2'h1
`define SED_ERASE_EVERYTHING_CMD 2'h2
`define SED_PROGRAM_ENABLE_CMD 2'h3

// ==========================================
// Serial clocks per frame
`define SED_CLKS_BYTE_CMD 5'hc
`define SED_CLKS_BYTE_DATA 5'h14
`define SED_CLKS_WORD_CMD 5'hb
`define SED_CLKS_WORD_DATA 5'h1b
`define SED_FRAME_BITS 27

// ==========================================
// Memory values and layout
`define SED_ERASED_WORD 16'hffff
`define SED_WORDS 128

// ==========================================
// Timing
`define SED_CLK_MHZ 50
`define SED_TWP_MS 5
`define SED_TCS_NS 200
`define SED_TWP_CYCLES (`SED_TWP_MS * 1000 * `SED_CLK_MHZ)
`define SED_TCS_CYCLES ((`SED_TCS_NS * `SED_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/sed_pkg.sv ***
// Types shared by both ends of the serial EEPROM command link.
// Assumes sed_defs.svh supplies the numeric constants.
`default_nettype none

package sed_pkg;
	typedef enum logic [4:0] {
		DS_RESET = 5'h01,
		DS_STANDBY = 5'h02,
		DS_SHIFT = 5'h04,
		DS_READ = 5'h08,
		DS_PROG = 5'h10
	} sed_dev_state_e;

	typedef enum logic [4:0] {
		HS_IDLE = 5'h01,
		HS_SHIFT = 5'h02,
		HS_READ = 5'h04,
		HS_GAP = 5'h08,
		HS_POLL = 5'h10
	} sed_host_state_e;

	typedef logic [15:0] sed_word_t;
endpackage : sed_pkg

`default_nettype wire

// *** rtl/sed_link_if.sv ***
// Four-wire serial link between host controller and EEPROM decoder.
// Assumes both ends run on the same core_clk; the data-out wire is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface sed_link_if;
	logic chipSelect;
	logic serialClockIn;
	logic dataIn;
	logic dataOut;
	logic dataOutEn;
	logic dataOutLevel;

	// Undriven data-out reads low, which the host takes as busy
	assign dataOutLevel = dataOutEn & dataOut;

	modport device (
		input chipSelect,
		input serialClockIn,
		input dataIn,
		output dataOut,
		output dataOutEn
	);

	modport host (
		output chipSelect,
		output serialClockIn,
		output dataIn,
		input dataOutLevel
	);
endinterface : sed_link_if

`default_nettype wire

// *** rtl/sed_device.sv ***
// EEPROM end: decodes serial frames, holds the 2-kbit array, reports status.
// Assumes the link pins come from another party and are synchronised here.
//
// Notes on behaviour
// - Opcode 00 sub-command in top address bits
// - Fill-everything carries one word; 20/27 clocks
// - 01 write, 10 read, 11 erase one
// - Width select high: 16-bit, else 8-bit
// - Host gives exact clock count per frame
// - Ignore frames during reset, then standby
// - Reset reassertion returns to reset state
// - Standby only after operation and programming end
// - Host waits for ready before next frame
// - Sample data on rising clock; start bit one
// - Read: zero, data MSB first, wrapping stream
// - Programming disabled until enable command
// - Select fall starts timer; status on data-out
`timescale 1ns/1ps
`default_nettype none
`include "sed_defs.svh"

module sed_device #(
	parameter int unsigned PROG_CYCLES = `SED_TWP_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	sed_link_if.device link,
	input wire logic wordWidthSelect,
	output logic standby,
	output logic programEnabled,
	output logic progBusy
);
	// ==========================================
	// Parameter check
	if (PROG_CYCLES < 1 || PROG_CYCLES > 24'hffffff) begin : gBadCycles
		$error("PROG_CYCLES must be 1 to 16777215");
	end

	// ==========================================
	// Helpers
	function automatic logic [6:0] idxOf(input logic [7:0] a, input logic b);
		idxOf = b ? a[7:1] : a[6:0];
	endfunction : idxOf

	function automatic logic [15:0] pick(input logic [15:0] w, input logic a0, input logic b);
		pick = b ? (a0 ? {w[15:8], 8'h00} : {w[7:0], 8'h00}) : w;
	endfunction : pick

	function automatic logic [15:0] merge(input logic [15:0] w, input logic [15:0] d, input logic a0,
		input logic b);
		merge = b ? (a0 ? {d[7:0], w[7:0]} : {w[15:8], d[7:0]}) : d;
	endfunction : merge

	// ==========================================
	// Pin synchronisers
	logic csS1, csS2, skS1, skS2, skPrev, diS1, diS2, orgS1, orgS2;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			{csS1, csS2, skS1, skS2, skPrev, diS1, diS2} <= 7'h00;
			{orgS1, orgS2} <= 2'h3;
		end else begin
			csS1 <= link.chipSelect;
			csS2 <= csS1;
			skS1 <= link.serialClockIn;
			skS2 <= skS1;
			skPrev <= skS2;
			diS1 <= link.dataIn;
			diS2 <= diS1;
			orgS1 <= wordWidthSelect;
			orgS2 <= orgS1;
		end
	end

	logic rise;
	assign rise = csS2 & skS2 & ~skPrev;

	// ==========================================
	// Control state
	sed_pkg::sed_dev_state_e state_r, state_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [26:0] sh_r, sh_nxt;
	logic [1:0] op_r, op_nxt, sub_r, sub_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic byte_r, byte_nxt, wen_r, wen_nxt, arm_r, arm_nxt;
	logic [23:0] timer_r, timer_nxt;
	logic [15:0] out_r, out_nxt;
	logic [3:0] outCnt_r, outCnt_nxt;
	logic dout_r, dout_nxt, doutEn_r, doutEn_nxt, standby_r, standby_nxt;
	logic memOne, memAll, memA0;
	logic [6:0] memIdx;
	logic [15:0] memVal;
	sed_pkg::sed_word_t mem_r [`SED_WORDS];
	sed_pkg::sed_word_t memNxt [`SED_WORDS];

	logic [4:0] cmdClks, dataClks;
	logic [26:0] newSh;
	logic [7:0] nextAddr, newAddr;
	logic okCmd, okData, startProg;

	assign cmdClks = byte_r ? `SED_CLKS_BYTE_CMD : `SED_CLKS_WORD_CMD;
	assign dataClks = byte_r ? `SED_CLKS_BYTE_DATA : `SED_CLKS_WORD_DATA;
	assign newSh = {sh_r[25:0], diS2};
	assign nextAddr = byte_r ? addr_r + 8'h01 : {1'b0, addr_r[6:0] + 7'h01};
	assign newAddr = byte_r ? newSh[7:0] : {1'b0, newSh[6:0]};
	assign okCmd = cnt_r == cmdClks;
	assign okData = cnt_r == dataClks;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		op_nxt = op_r;
		sub_nxt = sub_r;
		addr_nxt = addr_r;
		byte_nxt = byte_r;
		wen_nxt = wen_r;
		arm_nxt = arm_r;
		timer_nxt = timer_r;
		out_nxt = out_r;
		outCnt_nxt = outCnt_r;
		dout_nxt = dout_r;
		doutEn_nxt = 1'b0;
		memOne = 1'b0;
		memAll = 1'b0;
		memA0 = addr_r[0];
		memIdx = idxOf(addr_r, byte_r);
		memVal = `SED_ERASED_WORD;
		startProg = 1'b0;
		case (state_r)
			sed_pkg::DS_RESET: begin
				state_nxt = sed_pkg::DS_STANDBY;
			end
			sed_pkg::DS_STANDBY: begin
				if (rise && diS2) begin
					state_nxt = sed_pkg::DS_SHIFT;
					cnt_nxt = 5'h01;
					sh_nxt = 27'h0000001;
					byte_nxt = ~orgS2;
					arm_nxt = 1'b0;
				end
			end
			sed_pkg::DS_SHIFT: begin
				if (!csS2) begin
					state_nxt = sed_pkg::DS_STANDBY;
					arm_nxt = op_r != `SED_OP_READ && !(op_r == `SED_OP_CTRL && sub_r[1] == sub_r[0]);
					if (op_r == `SED_OP_CTRL && okCmd) begin
						case (sub_r)
							`SED_PROGRAM_DISABLE_CMD: wen_nxt = 1'b0;
							`SED_PROGRAM_ENABLE_CMD: wen_nxt = 1'b1;
							`SED_ERASE_EVERYTHING_CMD: begin
								memAll = wen_r;
								startProg = wen_r;
							end
							default: ;
						endcase
					end
					if (op_r == `SED_OP_CTRL && sub_r == `SED_FILL_EVERYTHING_CMD && okData && wen_r) begin
						memAll = 1'b1;
						memVal = byte_r ? {sh_r[7:0], sh_r[7:0]} : sh_r[15:0];
						startProg = 1'b1;
					end
					if (op_r == `SED_OP_WRITE && okData && wen_r) begin
						memOne = 1'b1;
						memVal = sh_r[15:0];
						startProg = 1'b1;
					end
					if (op_r == `SED_OP_ERASE && okCmd && wen_r) begin
						memOne = 1'b1;
						startProg = 1'b1;
					end
					if (startProg) begin
						state_nxt = sed_pkg::DS_PROG;
						timer_nxt = 24'(PROG_CYCLES - 1);
						arm_nxt = 1'b1;
					end
				end else if (rise) begin
					cnt_nxt = (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h01;
					sh_nxt = newSh;
					if (cnt_r + 5'h01 == cmdClks) begin
						op_nxt = byte_r ? newSh[10:9] : newSh[9:8];
						sub_nxt = byte_r ? newSh[8:7] : newSh[7:6];
						addr_nxt = newAddr;
						if ((byte_r ? newSh[10:9] : newSh[9:8]) == `SED_OP_READ) begin
							state_nxt = sed_pkg::DS_READ;
							out_nxt = pick(mem_r[idxOf(newAddr, byte_r)], newAddr[0], byte_r);
							outCnt_nxt = 4'h0;
							dout_nxt = 1'b0;
						end
					end
				end
			end
			sed_pkg::DS_READ: begin
				if (!csS2) begin
					state_nxt = sed_pkg::DS_STANDBY;
				end else begin
					doutEn_nxt = 1'b1;
					if (rise) begin
						dout_nxt = out_r[15];
						out_nxt = {out_r[14:0], 1'b0};
						outCnt_nxt = outCnt_r + 4'h1;
						if (outCnt_r == (byte_r ? 4'h7 : 4'hf)) begin
							addr_nxt = nextAddr;
							out_nxt = pick(mem_r[idxOf(nextAddr, byte_r)], nextAddr[0], byte_r);
							outCnt_nxt = 4'h0;
						end
					end
				end
			end
			sed_pkg::DS_PROG: begin
				// Frames arriving now are not decoded
				if (timer_r == 24'h000000) begin
					state_nxt = sed_pkg::DS_STANDBY;
				end else begin
					timer_nxt = timer_r - 24'h000001;
				end
			end
			default: state_nxt = sed_pkg::DS_RESET;
		endcase
		// Status stays readable until select drops, even after completion
		if (arm_r && csS2 && (state_r == sed_pkg::DS_PROG || state_r == sed_pkg::DS_STANDBY)) begin
			doutEn_nxt = 1'b1;
			dout_nxt = state_r != sed_pkg::DS_PROG;
		end
		if (arm_r && !csS2 && doutEn_r && state_r == sed_pkg::DS_STANDBY) begin
			arm_nxt = 1'b0;
		end
		standby_nxt = state_nxt == sed_pkg::DS_STANDBY && !csS2;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= sed_pkg::DS_RESET;
			cnt_r <= 5'h00;
			sh_r <= 27'h0000000;
			op_r <= 2'h0;
			sub_r <= 2'h0;
			addr_r <= 8'h00;
			byte_r <= 1'b0;
			wen_r <= 1'b0;
			arm_r <= 1'b0;
			timer_r <= 24'h000000;
			out_r <= 16'h0000;
			outCnt_r <= 4'h0;
			dout_r <= 1'b0;
			doutEn_r <= 1'b0;
			standby_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			op_r <= op_nxt;
			sub_r <= sub_nxt;
			addr_r <= addr_nxt;
			byte_r <= byte_nxt;
			wen_r <= wen_nxt;
			arm_r <= arm_nxt;
			timer_r <= timer_nxt;
			out_r <= out_nxt;
			outCnt_r <= outCnt_nxt;
			dout_r <= dout_nxt;
			doutEn_r <= doutEn_nxt;
			standby_r <= standby_nxt;
		end
	end

	// ==========================================
	// Array; not reset, it models nonvolatile cells
	always_comb begin
		for (int i = 0; i < `SED_WORDS; i++) begin
			memNxt[i] = mem_r[i];
			if (resetn && (memAll || (memOne && memIdx == 7'(i)))) begin
				memNxt[i] = memAll ? memVal : merge(mem_r[i], memVal, memA0, byte_r);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		mem_r <= memNxt;
	end

	assign link.dataOut = dout_r;
	assign link.dataOutEn = doutEn_r;
	assign standby = standby_r;
	assign programEnabled = wen_r;
	assign progBusy = state_r == sed_pkg::DS_PROG;
endmodule : sed_device

`default_nettype wire

// *** rtl/sed_host.sv ***
// Host end: turns user commands into serial frames and collects read words.
// Assumes the device answers within a few core_clk cycles of each clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "sed_defs.svh"

module sed_host #(
	parameter int unsigned HALF_DIV = 13,
	parameter int unsigned DATA_W = 16,
	parameter int unsigned DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic resetn,
	sed_link_if.host link,
	input wire logic wordWidthSelect,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic [1:0] cmdOp,
	input wire logic [1:0] cmdSub,
	input wire logic [7:0] cmdAddr,
	input wire logic [15:0] cmdData,
	input wire logic [7:0] cmdReadWords,
	output logic rdValid,
	input wire logic rdReady,
	output logic [DATA_W-1:0] rdData
);
	// ==========================================
	// Parameter check
	if (HALF_DIV < 8 || HALF_DIV > 255 || DATA_W != 16 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBad
		$error("HALF_DIV 8..255, DATA_W 16, DEPTH a power of two from 2");
	end
	localparam int unsigned PW = $clog2(DEPTH);

	// ==========================================
	// Data-out synchroniser
	logic doS1, doS2;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			doS1 <= 1'b0;
			doS2 <= 1'b0;
		end else begin
			doS1 <= link.dataOutLevel;
			doS2 <= doS1;
		end
	end

	// ==========================================
	// Frame sequencer
	sed_pkg::sed_host_state_e state_r, state_nxt;
	logic [7:0] div_r, div_nxt, gap_r, gap_nxt, words_r, words_nxt;
	logic sclk_r, sclk_nxt, cs_r, cs_nxt, din_r, din_nxt, isRead_r, isRead_nxt, stat_r, stat_nxt;
	logic byte_r, byte_nxt;
	logic [26:0] frame_r, frame_nxt;
	logic [4:0] left_r, left_nxt;
	logic [15:0] rx_r, rx_nxt;
	logic [3:0] rxCnt_r, rxCnt_nxt;
	logic push, pop, space, tick, isCtrl, hasData, bm;
	logic [15:0] pushData;
	logic [DATA_W-1:0] fifo_r [DEPTH];
	logic [PW-1:0] wp_r, rp_r;
	logic [PW:0] fcnt_r;

	assign tick = div_r == 8'(HALF_DIV - 1);
	assign space = fcnt_r < (PW + 1)'(DEPTH);
	assign bm = ~wordWidthSelect;
	assign isCtrl = cmdOp == `SED_OP_CTRL;
	assign hasData = cmdOp == `SED_OP_WRITE || (isCtrl && cmdSub == `SED_FILL_EVERYTHING_CMD);

	always_comb begin
		state_nxt = state_r;
		div_nxt = (state_r == sed_pkg::HS_SHIFT || state_r == sed_pkg::HS_READ) ? div_r + 8'h01 : 8'h00;
		gap_nxt = gap_r;
		words_nxt = words_r;
		sclk_nxt = sclk_r;
		cs_nxt = cs_r;
		din_nxt = din_r;
		isRead_nxt = isRead_r;
		stat_nxt = stat_r;
		byte_nxt = byte_r;
		frame_nxt = frame_r;
		left_nxt = left_r;
		rx_nxt = rx_r;
		rxCnt_nxt = rxCnt_r;
		push = 1'b0;
		pushData = byte_r ? {8'h00, rx_r[6:0], doS2} : {rx_r[14:0], doS2};
		case (state_r)
			sed_pkg::HS_IDLE: begin
				if (cmdValid) begin
					state_nxt = sed_pkg::HS_SHIFT;
					byte_nxt = bm;
					frame_nxt = bm ? {1'b1, cmdOp, isCtrl ? {cmdSub, 7'h00} : {1'b0, cmdAddr}, cmdData[7:0], 7'h00}
						: {1'b1, cmdOp, isCtrl ? {cmdSub, 6'h00} : {1'b0, cmdAddr[6:0]}, cmdData};
					left_nxt = bm ? (hasData ? `SED_CLKS_BYTE_DATA : `SED_CLKS_BYTE_CMD)
						: (hasData ? `SED_CLKS_WORD_DATA : `SED_CLKS_WORD_CMD);
					isRead_nxt = cmdOp == `SED_OP_READ;
					stat_nxt = cmdOp == `SED_OP_WRITE || cmdOp == `SED_OP_ERASE
						|| (isCtrl && (cmdSub == `SED_FILL_EVERYTHING_CMD || cmdSub == `SED_ERASE_EVERYTHING_CMD));
					words_nxt = (cmdReadWords == 8'h00) ? 8'h01 : cmdReadWords;
					cs_nxt = 1'b1;
					din_nxt = 1'b1;
				end
			end
			sed_pkg::HS_SHIFT: begin
				if (tick) begin
					div_nxt = 8'h00;
					sclk_nxt = ~sclk_r;
					if (sclk_r) begin
						left_nxt = left_r - 5'h01;
						frame_nxt = {frame_r[25:0], 1'b0};
						din_nxt = frame_r[25];
						if (left_r == 5'h01) begin
							din_nxt = 1'b0;
							rxCnt_nxt = 4'h0;
							state_nxt = isRead_r ? sed_pkg::HS_READ : sed_pkg::HS_GAP;
							cs_nxt = isRead_r;
							gap_nxt = 8'h00;
						end
					end
				end
			end
			sed_pkg::HS_READ: begin
				if (tick) begin
					// A full buffer holds the serial clock low, so no word is lost
					div_nxt = (!sclk_r && !space) ? div_r : 8'h00;
					if (!sclk_r) begin
						sclk_nxt = space;
					end else begin
						sclk_nxt = 1'b0;
						rx_nxt = {rx_r[14:0], doS2};
						rxCnt_nxt = rxCnt_r + 4'h1;
						if (rxCnt_r == (byte_r ? 4'h7 : 4'hf)) begin
							push = 1'b1;
							rxCnt_nxt = 4'h0;
							words_nxt = words_r - 8'h01;
							if (words_r == 8'h01) begin
								state_nxt = sed_pkg::HS_GAP;
								cs_nxt = 1'b0;
								gap_nxt = 8'h00;
							end
						end
					end
				end
			end
			sed_pkg::HS_GAP: begin
				gap_nxt = gap_r + 8'h01;
				if (gap_r == 8'(`SED_TCS_CYCLES - 1)) begin
					state_nxt = stat_r ? sed_pkg::HS_POLL : sed_pkg::HS_IDLE;
					cs_nxt = stat_r;
				end
			end
			sed_pkg::HS_POLL: begin
				if (doS2) begin
					state_nxt = sed_pkg::HS_GAP;
					stat_nxt = 1'b0;
					cs_nxt = 1'b0;
					gap_nxt = 8'h00;
				end
			end
			default: state_nxt = sed_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= sed_pkg::HS_IDLE;
			{div_r, gap_r, words_r} <= 24'h000000;
			{sclk_r, cs_r, din_r, isRead_r, stat_r, byte_r} <= 6'h00;
			frame_r <= 27'h0000000;
			left_r <= 5'h00;
			rx_r <= 16'h0000;
			rxCnt_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			gap_r <= gap_nxt;
			words_r <= words_nxt;
			{sclk_r, cs_r, din_r, isRead_r, stat_r, byte_r} <= {sclk_nxt, cs_nxt, din_nxt, isRead_nxt, stat_nxt, byte_nxt};
			frame_r <= frame_nxt;
			left_r <= left_nxt;
			rx_r <= rx_nxt;
			rxCnt_r <= rxCnt_nxt;
		end
	end

	// ==========================================
	// Read buffer
	assign pop = rdValid & rdReady;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
			fcnt_r <= '0;
		end else begin
			if (push) begin
				fifo_r[wp_r] <= pushData;
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			fcnt_r <= fcnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
		end
	end

	assign rdValid = fcnt_r != '0;
	assign rdData = fifo_r[rp_r];
	assign cmdReady = state_r == sed_pkg::HS_IDLE;
	assign link.chipSelect = cs_r;
	assign link.serialClockIn = sclk_r;
	assign link.dataIn = din_r;
endmodule : sed_host

`default_nettype wire

// *** bench/sed_link_sva.sv ***
// Concurrent checks on the serial link between host end and EEPROM end.
// Assumes it sits beside sed_link_if and sees the device status outputs.
`timescale 1ns/1ps
`default_nettype none
`include "sed_defs.svh"

module sed_link_sva #(
	parameter int unsigned PROG_CYCLES = `SED_TWP_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic chipSelect,
	input wire logic serialClockIn,
	input wire logic dataOut,
	input wire logic dataOutEn,
	input wire logic dataOutLevel,
	input wire logic progBusy,
	input wire logic programEnabled,
	input wire logic standby
);
	// ==========================================
	// Busy-time counter
	logic [31:0] busyCnt_r;
	logic [31:0] busyCnt_nxt;

	always_comb begin
		busyCnt_nxt = progBusy ? busyCnt_r + 32'h1 : 32'h0;
	end

	always_ff @(posedge core_clk) begin
		busyCnt_r <= resetn ? busyCnt_nxt : 32'h0;
	end

	// ==========================================
	// Properties
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Status is stale for a few cycles after a select edge
	sequence pollHeld;
		chipSelect [*4];
	endsequence

	sequence readyShown;
		##[1:8] dataOutLevel;
	endsequence

	reset_quiet_a: assert property (disable iff (1'b0)
		!resetn |=> !progBusy && !programEnabled && !standby && !dataOutEn) else $error("status active in reset");
	standby_up_a: assert property ($rose(resetn) |-> ##[1:3] standby)
		else $error("no standby after reset");
	busy_no_standby_a: assert property (progBusy |-> !standby)
		else $error("standby while programming");
	enable_first_a: assert property ($rose(progBusy) |-> $past(programEnabled))
		else $error("programming while disabled");
	busy_status_a: assert property (pollHeld ##0 (progBusy && $past(progBusy, 4) && dataOutEn) |-> !dataOut)
		else $error("ready shown while busy");
	ready_status_a: assert property ($fell(progBusy) && chipSelect |-> readyShown)
		else $error("ready not shown");
	prog_time_a: assert property ($fell(progBusy) |-> busyCnt_r == PROG_CYCLES)
		else $error("programming time wrong");
	clock_framed_a: assert property ($rose(serialClockIn) |-> chipSelect)
		else $error("clock edge outside frame");
	out_release_a: assert property ($fell(chipSelect) |-> ##[1:4] !dataOutEn)
		else $error("data-out not released");
endmodule : sed_link_sva

`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench: host end and EEPROM end joined by the link interface.
// Assumes a shortened programming time; array contents start unknown.
`timescale 1ns/1ps
`default_nettype none
`include "sed_defs.svh"

module testbench;
	localparam int unsigned PROG = 20;
	logic core_clk, resetn, wordWidthSelect, cmdValid, cmdReady, rdValid, rdReady;
	logic standby, programEnabled, progBusy, hostWide;
	logic [1:0] cmdOp, cmdSub;
	logic [7:0] cmdAddr, cmdReadWords;
	logic [15:0] cmdData, rdData;
	int mismatches = 0;
	int comparisons = 0;

	sed_link_if i_sed_link_if ();
	sed_device #(.PROG_CYCLES(PROG)) i_sed_device (.core_clk(core_clk), .resetn(resetn),
		.link(i_sed_link_if.device), .wordWidthSelect(wordWidthSelect), .standby(standby),
		.programEnabled(programEnabled), .progBusy(progBusy));
	sed_host #(.HALF_DIV(8)) i_sed_host (.core_clk(core_clk), .resetn(resetn), .link(i_sed_link_if.host),
		.wordWidthSelect(hostWide), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdSub(cmdSub), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReadWords(cmdReadWords),
		.rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
	sed_link_sva #(.PROG_CYCLES(PROG)) i_sed_link_sva (.core_clk(core_clk), .resetn(resetn),
		.chipSelect(i_sed_link_if.chipSelect), .serialClockIn(i_sed_link_if.serialClockIn),
		.dataOut(i_sed_link_if.dataOut), .dataOutEn(i_sed_link_if.dataOutEn),
		.dataOutLevel(i_sed_link_if.dataOutLevel), .progBusy(progBusy),
		.programEnabled(programEnabled), .standby(standby));

	// ==========================================
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			#1;
		end
	endtask : tick

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wait_ready();
		for (int k = 0; k < 5000 && cmdReady !== 1'b1; k++) begin
			tick(1);
		end
		cmp({15'h0, cmdReady}, 16'h1);
	endtask : wait_ready

	task automatic cmd(input logic [1:0] op, input logic [1:0] sub, input logic [7:0] addr,
		input logic [15:0] data, input logic [7:0] n);
		wait_ready();
		cmdOp = op;
		cmdSub = sub;
		cmdAddr = addr;
		cmdData = data;
		cmdReadWords = n;
		cmdValid = 1'b1;
		tick(1);
		cmdValid = 1'b0;
	endtask : cmd

	task automatic pop(input logic [15:0] exp);
		for (int k = 0; k < 5000 && rdValid !== 1'b1; k++) begin
			tick(1);
		end
		cmp(rdData, exp);
		rdReady = 1'b1;
		tick(1);
		rdReady = 1'b0;
	endtask : pop

	// Reader stalls first so the two-entry buffer fills and the link pauses
	task automatic rd3(input logic [7:0] addr, input logic [15:0] e0, input logic [15:0] e1,
		input logic [15:0] e2);
		cmd(`SED_OP_READ, 2'h0, addr, 16'h0, 8'h3);
		tick(1000);
		pop(e0);
		pop(e1);
		pop(e2);
	endtask : rd3

	task automatic ctrl(input logic [1:0] sub, input logic [15:0] data);
		cmd(`SED_OP_CTRL, sub, 8'h0, data, 8'h1);
	endtask : ctrl

	// ==========================================
	// Scenarios
	task automatic t_power_up();
		cmp({15'h0, standby}, 16'h1);
		cmp({15'h0, programEnabled}, 16'h0);
		cmp({15'h0, progBusy}, 16'h0);
		$display("t_power_up done");
	endtask : t_power_up

	task automatic t_fill_wrap();
		ctrl(`SED_PROGRAM_ENABLE_CMD, 16'h0);
		wait_ready();
		cmp({15'h0, programEnabled}, 16'h1);
		ctrl(`SED_FILL_EVERYTHING_CMD, 16'ha5a5);
		rd3(8'h7e, 16'ha5a5, 16'ha5a5, 16'ha5a5);
		$display("t_fill_wrap done");
	endtask : t_fill_wrap

	task automatic t_guard();
		cmd(`SED_OP_WRITE, 2'h0, 8'h05, 16'h1234, 8'h1);
		cmd(`SED_OP_ERASE, 2'h0, 8'h06, 16'h0, 8'h1);
		ctrl(`SED_PROGRAM_DISABLE_CMD, 16'h0);
		wait_ready();
		cmp({15'h0, programEnabled}, 16'h0);
		cmd(`SED_OP_WRITE, 2'h0, 8'h05, 16'habcd, 8'h1);
		ctrl(`SED_ERASE_EVERYTHING_CMD, 16'h0);
		rd3(8'h04, 16'ha5a5, 16'h1234, 16'hffff);
		$display("t_guard done");
	endtask : t_guard

	task automatic t_busy();
		ctrl(`SED_PROGRAM_ENABLE_CMD, 16'h0);
		cmd(`SED_OP_WRITE, 2'h0, 8'h10, 16'h0f0f, 8'h1);
		for (int k = 0; k < 2000 && progBusy !== 1'b1; k++) begin
			tick(1);
		end
		cmp({15'h0, standby}, 16'h0);
		wait_ready();
		tick(3);
		cmp({15'h0, standby}, 16'h1);
		ctrl(`SED_ERASE_EVERYTHING_CMD, 16'h0);
		rd3(8'h0f, 16'hffff, 16'hffff, 16'hffff);
		$display("t_busy done");
	endtask : t_busy

	task automatic t_bytes();
		wait_ready();
		wordWidthSelect = 1'b0;
		hostWide = 1'b0;
		tick(5);
		ctrl(`SED_FILL_EVERYTHING_CMD, 16'h005a);
		cmd(`SED_OP_WRITE, 2'h0, 8'h80, 16'h00c3, 8'h1);
		cmd(`SED_OP_WRITE, 2'h0, 8'h81, 16'h003c, 8'h1);
		rd3(8'h7f, 16'h005a, 16'h00c3, 16'h003c);
		wait_ready();
		wordWidthSelect = 1'b1;
		hostWide = 1'b1;
		tick(5);
		rd3(8'h3f, 16'h5a5a, 16'h3cc3, 16'h5a5a);
		$display("t_bytes done");
	endtask : t_bytes

	// Array strapped for bytes, host still framing words: every clock count is wrong
	task automatic t_bad_count();
		wait_ready();
		wordWidthSelect = 1'b0;
		tick(5);
		cmd(`SED_OP_WRITE, 2'h0, 8'h3f, 16'h9999, 8'h1);
		ctrl(`SED_PROGRAM_DISABLE_CMD, 16'h0);
		wait_ready();
		cmp({15'h0, programEnabled}, 16'h1);
		wordWidthSelect = 1'b1;
		tick(5);
		rd3(8'h3f, 16'h5a5a, 16'h3cc3, 16'h5a5a);
		$display("t_bad_count done");
	endtask : t_bad_count

	// Supply loss in mid-programming must drop the enable latch too
	task automatic t_brownout();
		cmd(`SED_OP_WRITE, 2'h0, 8'h20, 16'h1111, 8'h1);
		for (int k = 0; k < 2000 && progBusy !== 1'b1; k++) begin
			tick(1);
		end
		resetn = 1'b0;
		tick(4);
		cmp({15'h0, progBusy}, 16'h0);
		cmp({15'h0, programEnabled}, 16'h0);
		resetn = 1'b1;
		tick(4);
		cmp({15'h0, standby}, 16'h1);
		$display("t_brownout done");
	endtask : t_brownout

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================
	// Clock, watchdog, main sequence
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		resetn = 1'b0;
		wordWidthSelect = 1'b1;
		hostWide = 1'b1;
		cmdValid = 1'b0;
		rdReady = 1'b0;
		cmdOp = 2'h0;
		cmdSub = 2'h0;
		cmdAddr = 8'h0;
		cmdData = 16'h0;
		cmdReadWords = 8'h1;
		tick(4);
		resetn = 1'b1;
		tick(4);
		t_power_up();
		t_fill_wrap();
		t_guard();
		t_busy();
		t_bytes();
		t_bad_count();
		t_brownout();
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
